// ---- design/rbt_pkg.sv ----
// Purpose: Shared constants for the registered bus transceiver
// Assumes: Single 200 MHz system clock, capture clocks sampled as levels
// Notes: Constants only, no logic
`default_nettype none

package rbt_pkg;
  // Section geometry
  localparam int SEC_W = 9;
  localparam int NUM_SEC = 2;
  localparam int BUS_W = SEC_W * NUM_SEC;
  // Capture log word: one capture-edge flag per clock input, then both buses
  localparam int EVT_W = 2 * NUM_SEC;
  localparam int LOG_W = EVT_W + 2 * BUS_W;
  localparam int LOG_EVT_LSB = 2 * BUS_W;
  localparam int LOG_B_LSB = BUS_W;
  localparam int LOG_A_LSB = 0;
  localparam int LOG_DEPTH = 8;
  // Reset values of held state
  localparam logic [SEC_W-1:0] STORE_RST = 9'h000;
  localparam logic [BUS_W-1:0] SNAP_RST = 18'h00000;
  localparam int CLK_PERIOD_NS = 5;
  // Direction encoding
  typedef enum logic [0:0]
  {
    RBT_DIR_B_TO_A = 1'b0,
    RBT_DIR_A_TO_B = 1'b1
  } rbt_dir_t;
endpackage

`default_nettype wire

// ---- design/rbt_fifo.sv ----
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: One clock, asynchronous active-high reset
// Notes: Read data comes from storage flops; full and empty are exact
`default_nettype none

module rbt_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_push;
  logic do_pop;

  // Handshakes are combinational so back-pressure reaches the source at once
  assign in_ready_o = (count != FULL_CNT);
  assign out_valid_o = (count != '0);
  assign do_push = in_valid_i && in_ready_o;
  assign do_pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr];

  // Storage array, no reset needed on data
  always_ff @(posedge clk_i)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr <= (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // Occupancy
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      count <= '0;
    end
    else if (do_push && !do_pop)
    begin
      count <= count + 1'b1;
    end
    else if (do_pop && !do_push)
    begin
      count <= count - 1'b1;
    end
  end
endmodule // rbt_fifo

`default_nettype wire

// ---- design/rbt_edge.sv ----
// Purpose: Rising-edge detector for capture clock levels
// Assumes: Input is synchronous to clk_i
// Notes: Reset state is high so a level already high at release is no edge
`default_nettype none

module rbt_edge #(
  parameter int N = 1
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [N-1:0] level_i,
  output logic [N-1:0] rise_o
);
  logic [N-1:0] prev;

  // Previous level; starting high avoids a false edge after reset
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      prev <= '1;
    end
    else
    begin
      prev <= level_i;
    end
  end

  assign rise_o = level_i & ~prev;
endmodule // rbt_edge

`default_nettype wire

// ---- design/rbt_top.sv ----
// Purpose: Normal-mode datapath of a two-section registered bus transceiver
// Assumes: All control and pin inputs synchronous to clk_i (200 MHz)
// Notes: Pins are split into input, output and enable; the bench resolves wires
//        Pin outputs are combinational, since transparent transfer allows no flop
//        Storage resets to zero; the pins themselves define no reset value
//        Capture clocks are sampled levels and must stay low one cycle between edges
//        Sections share the clock, reset, test mode, snapshot request and capture log
//
// Notes on behaviour
// - Enable low: drive B from A when direction high, A from B when low.
// - Enable high: both ports released; stored values hold without capture edges.
// - Rising A capture clock loads A port value into A storage.
// - B select low: B outputs follow live A inputs combinationally.
// - B select high: B outputs show A storage contents.
// - B capture clock and A select mirror their A-side counterparts.
// - Two independent 9-bit sections, each with its own controls.
// - Capture never gated by enable or direction; driven pins still stored.
// - A select high while driving A: A shows B storage, not live B.
// - Test mode inhibits transceiver and storage; test logic owns pins.
// - Sampling pins in normal mode leaves the transceiver undisturbed.
`default_nettype none

module rbt_top #(
  parameter int SEC_W = rbt_pkg::SEC_W,
  parameter int NUM_SEC = rbt_pkg::NUM_SEC,
  parameter int LOG_DEPTH = rbt_pkg::LOG_DEPTH
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Per-section controls
  input wire logic [NUM_SEC-1:0] oe_n_i,
  input wire logic [NUM_SEC-1:0] dir_i,
  input wire logic [NUM_SEC-1:0] a_capture_clock_i,
  input wire logic [NUM_SEC-1:0] b_capture_clock_i,
  input wire logic [NUM_SEC-1:0] b_side_source_select_i,
  input wire logic [NUM_SEC-1:0] a_side_source_select_i,
  // A port pins
  input wire logic [SEC_W*NUM_SEC-1:0] a_in_i,
  output logic [SEC_W*NUM_SEC-1:0] a_out_o,
  output logic [SEC_W*NUM_SEC-1:0] a_oe_o,
  // B port pins
  input wire logic [SEC_W*NUM_SEC-1:0] b_in_i,
  output logic [SEC_W*NUM_SEC-1:0] b_out_o,
  output logic [SEC_W*NUM_SEC-1:0] b_oe_o,
  // Test mode takeover and pin snapshot
  input wire logic test_mode_i,
  input wire logic [SEC_W*NUM_SEC-1:0] test_a_out_i,
  input wire logic [SEC_W*NUM_SEC-1:0] test_a_oe_i,
  input wire logic [SEC_W*NUM_SEC-1:0] test_b_out_i,
  input wire logic [SEC_W*NUM_SEC-1:0] test_b_oe_i,
  input wire logic sample_i,
  output logic [SEC_W*NUM_SEC-1:0] sample_a_o,
  output logic [SEC_W*NUM_SEC-1:0] sample_b_o,
  output logic sample_valid_o,
  // Capture log stream
  output logic log_valid_o,
  input wire logic log_ready_i,
  output logic [2*NUM_SEC+2*SEC_W*NUM_SEC-1:0] log_data_o,
  output logic log_accept_o,
  output logic log_drop_o,
  // Stored values, visible for observation
  output logic [SEC_W*NUM_SEC-1:0] a_store_o,
  output logic [SEC_W*NUM_SEC-1:0] b_store_o
);
  // Derived widths, equal to the package's when defaults are used
  localparam int BUS_W = SEC_W * NUM_SEC;
  localparam int EVT_W = 2 * NUM_SEC;
  localparam int LOG_W = EVT_W + 2 * BUS_W;

  // Capture edges before and after the test-mode gate
  logic [NUM_SEC-1:0] a_rise;
  logic [NUM_SEC-1:0] b_rise;
  logic [NUM_SEC-1:0] a_cap;
  logic [NUM_SEC-1:0] b_cap;

  // Port ownership per section
  logic [NUM_SEC-1:0] drive_a;
  logic [NUM_SEC-1:0] drive_b;

  // Normal-mode pin values and enables
  logic [BUS_W-1:0] norm_a_out;
  logic [BUS_W-1:0] norm_b_out;
  logic [BUS_W-1:0] norm_a_oe;
  logic [BUS_W-1:0] norm_b_oe;

  // Capture log fill side
  logic [LOG_W-1:0] log_word;
  logic log_push;
  logic log_in_ready;

  // Selects stored or live data for one section's driven port
  // A plain mux, so a select change reaches the pins in the same cycle
  function automatic logic [SEC_W-1:0] pick_source(
    input logic use_store,
    input logic [SEC_W-1:0] stored,
    input logic [SEC_W-1:0] live
  );
    pick_source = use_store ? stored : live;
  endfunction

  // Which port, if any, a section drives in normal mode
  // Both ports of one section can never be driven at once
  function automatic logic drives_port(
    input logic oe_n,
    input logic dir,
    input logic toward_b
  );
    drives_port = !oe_n && (dir == (toward_b ? rbt_pkg::RBT_DIR_A_TO_B
                                             : rbt_pkg::RBT_DIR_B_TO_A));
  endfunction

  // Capture edges, one detector for each clock group
  // Detectors keep tracking in test mode, so leaving it gives no false edge
  rbt_edge #(
    .N(NUM_SEC)
  ) u_a_edge (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .level_i(a_capture_clock_i),
    .rise_o(a_rise)
  );

  // B capture clocks
  rbt_edge #(
    .N(NUM_SEC)
  ) u_b_edge (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .level_i(b_capture_clock_i),
    .rise_o(b_rise)
  );

  // Test mode blocks storage; enable and direction never gate capture
  // Gating after the detector keeps edge history exact across test mode
  assign a_cap = test_mode_i ? '0 : a_rise;
  assign b_cap = test_mode_i ? '0 : b_rise;

  // One independent slice per section
  genvar s;
  generate
    for (s = 0; s < NUM_SEC; s++)
    begin : g_sec
      logic [SEC_W-1:0] a_store;
      logic [SEC_W-1:0] b_store;
      logic [SEC_W-1:0] a_live;
      logic [SEC_W-1:0] b_live;

      // Live pin levels of this section
      assign a_live = a_in_i[s*SEC_W +: SEC_W];
      assign b_live = b_in_i[s*SEC_W +: SEC_W];

      // A storage: loads the A pins on each capture edge, else holds
      // A pin this section drives itself is stored as well
      always_ff @(posedge clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
        begin
          a_store <= rbt_pkg::STORE_RST;
        end
        else if (a_cap[s])
        begin
          a_store <= a_live;
        end
      end

      // B storage mirrors the A side
      // Same capture rule, fed from the B pins
      always_ff @(posedge clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
        begin
          b_store <= rbt_pkg::STORE_RST;
        end
        else if (b_cap[s])
        begin
          b_store <= b_live;
        end
      end

      // Port ownership from this section's own enable and direction
      assign drive_b[s] = drives_port(oe_n_i[s], dir_i[s], 1'b1);
      assign drive_a[s] = drives_port(oe_n_i[s], dir_i[s], 1'b0);

      // Transparent or registered source for each port
      // Each direction has its own select, so live and stored may mix
      assign norm_b_out[s*SEC_W +: SEC_W] =
        pick_source(b_side_source_select_i[s], a_store, a_live);
      assign norm_a_out[s*SEC_W +: SEC_W] =
        pick_source(a_side_source_select_i[s], b_store, b_live);

      // Released port gets no enable, so both buses isolate when off
      // Enables are spread to every bit of the section
      assign norm_b_oe[s*SEC_W +: SEC_W] = {SEC_W{drive_b[s]}};
      assign norm_a_oe[s*SEC_W +: SEC_W] = {SEC_W{drive_a[s]}};

      // Storage made visible for observation
      assign a_store_o[s*SEC_W +: SEC_W] = a_store;
      assign b_store_o[s*SEC_W +: SEC_W] = b_store;
    end
  endgenerate

  // A pin drivers; test mode hands them to the scan side
  always_comb
  begin
    if (test_mode_i)
    begin
      a_out_o = test_a_out_i;
      a_oe_o = test_a_oe_i;
    end
    else
    begin
      a_out_o = norm_a_out;
      a_oe_o = norm_a_oe;
    end
  end

  // B pin drivers; kept apart so each port's mux stands alone
  always_comb
  begin
    if (test_mode_i)
    begin
      b_out_o = test_b_out_i;
      b_oe_o = test_b_oe_i;
    end
    else
    begin
      b_out_o = norm_b_out;
      b_oe_o = norm_b_oe;
    end
  end

  // Pin snapshot; only observes, so normal datapath is untouched
  // Takes pin levels whoever drives them
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sample_a_o <= rbt_pkg::SNAP_RST;
      sample_b_o <= rbt_pkg::SNAP_RST;
    end
    else if (sample_i)
    begin
      sample_a_o <= a_in_i;
      sample_b_o <= b_in_i;
    end
  end

  // Snapshot valid pulse, one cycle after the request
  // Valid follows the request whether or not the pins changed
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sample_valid_o <= 1'b0;
    end
    else
    begin
      sample_valid_o <= sample_i;
    end
  end

  // Capture log word: edge flags, then B pins, then A pins
  // Pins are logged as seen at the edge, so driven ports show own drive
  assign log_word = {b_cap, a_cap, b_in_i, a_in_i};

  // One word per cycle covers every edge that fell in it
  assign log_push = (a_cap != '0) || (b_cap != '0);

  // Fill-side ready shown so a consumer can see when drops begin
  assign log_accept_o = log_in_ready;

  // Log copy of every capture; a full log drops entries, storage never waits
  // Overflow never stalls capture, which matters more than the log
  rbt_fifo #(
    .W(LOG_W),
    .DEPTH(LOG_DEPTH)
  ) u_log (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(log_push),
    .in_ready_o(log_in_ready),
    .in_data_i(log_word),
    .out_valid_o(log_valid_o),
    .out_ready_i(log_ready_i),
    .out_data_o(log_data_o)
  );

  // Sticky drop flag, cleared only by reset
  // Sticky so a slow consumer still learns that words were lost
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      log_drop_o <= 1'b0;
    end
    else if (log_push && !log_in_ready)
    begin
      log_drop_o <= 1'b1;
    end
  end
endmodule // rbt_top

`default_nettype wire

// ---- sim/rbt_bus_model.sv ----
// Purpose: Far-side buses A and B seen by the transceiver pins
// Assumes: Outside drivers always present, device drive wins per bit
// Notes: No bus hold on the pins; a released line takes the outside level
`default_nettype none

module rbt_bus_model (
  input wire logic [17:0] a_out_i,
  input wire logic [17:0] a_oe_i,
  input wire logic [17:0] a_drv_i,
  output logic [17:0] a_in_o,
  input wire logic [17:0] b_out_i,
  input wire logic [17:0] b_oe_i,
  input wire logic [17:0] b_drv_i,
  output logic [17:0] b_in_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Outside side yields wherever the device drives, so no contention
  assign a_in_o = (a_oe_i & a_out_i) | (~a_oe_i & a_drv_i);
  assign b_in_o = (b_oe_i & b_out_i) | (~b_oe_i & b_drv_i);
endmodule // rbt_bus_model

`default_nettype wire

// ---- sim/rbt_top_chk.sv ----
// Purpose: Port checks of the transceiver datapath
// Assumes: One clock, capture levels sampled on clk_i
// Notes: Section 0 checked in depth, section 1 for independence
`default_nettype none

module rbt_top_chk #(
  parameter int SEC_W = 9,
  parameter int NUM_SEC = 2
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [NUM_SEC-1:0] oe_n_i,
  input wire logic [NUM_SEC-1:0] dir_i,
  input wire logic [NUM_SEC-1:0] a_capture_clock_i,
  input wire logic [NUM_SEC-1:0] b_capture_clock_i,
  input wire logic [NUM_SEC-1:0] b_side_source_select_i,
  input wire logic [NUM_SEC-1:0] a_side_source_select_i,
  input wire logic [SEC_W*NUM_SEC-1:0] a_in_i,
  input wire logic [SEC_W*NUM_SEC-1:0] b_in_i,
  input wire logic [SEC_W*NUM_SEC-1:0] a_out_o,
  input wire logic [SEC_W*NUM_SEC-1:0] a_oe_o,
  input wire logic [SEC_W*NUM_SEC-1:0] b_out_o,
  input wire logic [SEC_W*NUM_SEC-1:0] b_oe_o,
  input wire logic test_mode_i,
  input wire logic [SEC_W*NUM_SEC-1:0] test_a_out_i,
  input wire logic sample_i,
  input wire logic [SEC_W*NUM_SEC-1:0] sample_a_o,
  input wire logic sample_valid_o,
  input wire logic [SEC_W*NUM_SEC-1:0] a_store_o,
  input wire logic [SEC_W*NUM_SEC-1:0] b_store_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Section 0 enabled in normal mode
  wire logic run0 = !test_mode_i && !oe_n_i[0];
  // Capture edges: low one cycle, high the next, outside test mode
  sequence s_arise;
    !a_capture_clock_i[0] ##1 a_capture_clock_i[0] && !test_mode_i;
  endsequence
  sequence s_brise;
    !b_capture_clock_i[0] ##1 b_capture_clock_i[0] && !test_mode_i;
  endsequence
  property p_dir;
    run0 |-> b_oe_o[SEC_W-1:0] == {SEC_W{dir_i[0]}} && a_oe_o[SEC_W-1:0] == {SEC_W{!dir_i[0]}};
  endproperty
  a_dir: assert property (p_dir) else $error("drive enables disagree with direction");
  property p_iso;
    !test_mode_i && oe_n_i[0] |-> a_oe_o[SEC_W-1:0] == 0 && b_oe_o[SEC_W-1:0] == 0;
  endproperty
  a_iso: assert property (p_iso) else $error("port driven while disabled");
  property p_acap;
    s_arise |=> a_store_o[SEC_W-1:0] == $past(a_in_i[SEC_W-1:0]);
  endproperty
  a_acap: assert property (p_acap) else $error("A capture missed");
  property p_bcap;
    s_brise |=> b_store_o[SEC_W-1:0] == $past(b_in_i[SEC_W-1:0]);
  endproperty
  a_bcap: assert property (p_bcap) else $error("B capture missed");
  property p_hold;
    !a_capture_clock_i[0] || test_mode_i |=> $stable(a_store_o[SEC_W-1:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("A storage changed without capture");
  property p_live;
    run0 && dir_i[0] && !b_side_source_select_i[0] |-> b_out_o[SEC_W-1:0] == a_in_i[SEC_W-1:0];
  endproperty
  a_live: assert property (p_live) else $error("B not following live A");
  property p_stab;
    run0 && dir_i[0] && b_side_source_select_i[0] |-> b_out_o[SEC_W-1:0] == a_store_o[SEC_W-1:0];
  endproperty
  a_stab: assert property (p_stab) else $error("B not showing A storage");
  property p_stba;
    run0 && !dir_i[0] && a_side_source_select_i[0] |-> a_out_o[SEC_W-1:0] == b_store_o[SEC_W-1:0];
  endproperty
  a_stba: assert property (p_stba) else $error("A not showing B storage");
  property p_sec1;
    !test_mode_i && !oe_n_i[1] && dir_i[1] && !b_side_source_select_i[1]
      |-> b_out_o[SEC_W +: SEC_W] == a_in_i[SEC_W +: SEC_W];
  endproperty
  a_sec1: assert property (p_sec1) else $error("section 1 path wrong");
  property p_tmode;
    test_mode_i |-> a_out_o == test_a_out_i;
  endproperty
  a_tmode: assert property (p_tmode) else $error("test drive not on A pins");
  property p_samp;
    sample_i |=> sample_valid_o && sample_a_o == $past(a_in_i);
  endproperty
  a_samp: assert property (p_samp) else $error("pin snapshot wrong");
endmodule // rbt_top_chk

bind rbt_top rbt_top_chk #(.SEC_W(SEC_W), .NUM_SEC(NUM_SEC)) u_chk (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .oe_n_i(oe_n_i), .dir_i(dir_i), .a_capture_clock_i(a_capture_clock_i),
  .b_capture_clock_i(b_capture_clock_i), .b_side_source_select_i(b_side_source_select_i),
  .a_side_source_select_i(a_side_source_select_i), .a_in_i(a_in_i), .b_in_i(b_in_i),
  .a_out_o(a_out_o), .a_oe_o(a_oe_o), .b_out_o(b_out_o), .b_oe_o(b_oe_o),
  .test_mode_i(test_mode_i), .test_a_out_i(test_a_out_i), .sample_i(sample_i),
  .sample_a_o(sample_a_o), .sample_valid_o(sample_valid_o), .a_store_o(a_store_o),
  .b_store_o(b_store_o));

`default_nettype wire

// ---- sim/rbt_top_tb.sv ----
// Purpose: Directed scenarios for the transceiver datapath and capture log
// Assumes: Inputs change at falling edges, checks at falling edges
// Notes: Direction only turns while disabled, as the outside buses require
`default_nettype none

module rbt_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'h0, sys_rst_i = 1'h1, test_mode_i = 1'h0, sample_i = 1'h0, log_ready = 1'h0;
  logic [1:0] oe_n = 2'h3, dir = 2'h0, acap = 2'h0, bcap = 2'h0, bsel = 2'h0, asel = 2'h0;
  logic [17:0] a_drv = 18'h00000, b_drv = 18'h00000, t_out = 18'h2AAAA, t_oe = 18'h3FFFF;
  logic [17:0] a_in, a_out, a_oe, b_in, b_out, b_oe, samp_a, samp_b, a_st, b_st;
  logic [39:0] log_data;
  logic log_valid, log_accept, log_drop, samp_valid;
  int fail_count = 0, checks_done = 0;
  // Half period of the 200 MHz clock
  always #2.5 clk_i = ~clk_i;
  rbt_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .oe_n_i(oe_n), .dir_i(dir),
    .a_capture_clock_i(acap), .b_capture_clock_i(bcap), .b_side_source_select_i(bsel),
    .a_side_source_select_i(asel), .a_in_i(a_in), .a_out_o(a_out), .a_oe_o(a_oe),
    .b_in_i(b_in), .b_out_o(b_out), .b_oe_o(b_oe), .test_mode_i(test_mode_i),
    .test_a_out_i(t_out), .test_a_oe_i(t_oe), .test_b_out_i(t_out), .test_b_oe_i(t_oe),
    .sample_i(sample_i), .sample_a_o(samp_a), .sample_b_o(samp_b), .sample_valid_o(samp_valid),
    .log_valid_o(log_valid), .log_ready_i(log_ready), .log_data_o(log_data),
    .log_accept_o(log_accept), .log_drop_o(log_drop), .a_store_o(a_st), .b_store_o(b_st));
  rbt_bus_model u_bus (.a_out_i(a_out), .a_oe_i(a_oe), .a_drv_i(a_drv), .a_in_o(a_in),
    .b_out_i(b_out), .b_oe_i(b_oe), .b_drv_i(b_drv), .b_in_o(b_in));
  // Shared compare
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // One capture pulse, low again before the next edge
  task automatic cap(input logic [1:0] a, input logic [1:0] b);
    acap = a;
    bcap = b;
    cyc(1);
    acap = 2'h0;
    bcap = 2'h0;
    cyc(1);
  endtask
  // Pop the log for a fixed 20 cycles, counting words; fixed so a stuck valid cannot hang
  task automatic drain(output int n);
    n = 0;
    log_ready = 1'h1;
    repeat (20)
    begin
      if (log_valid === 1'h1) n++;
      cyc(1);
    end
    log_ready = 1'h0;
  endtask
  // Direction turns only while the section is released
  task automatic t_xfer;
    dir = 2'h3;
    cyc(1);
    oe_n = 2'h0;
    a_drv = 18'h1B5A3;
    cyc(1);
    chk(b_in, 18'h1B5A3);
    chk({a_oe, b_oe}, {18'h00000, 18'h3FFFF});
    oe_n = 2'h3;
    cyc(1);
    chk({a_oe, b_oe}, 36'h0);
    dir = 2'h0;
    b_drv = 18'h0C3F5;
    cyc(1);
    oe_n = 2'h0;
    cyc(1);
    chk(a_in, 18'h0C3F5);
    chk({a_oe, b_oe}, {18'h3FFFF, 18'h00000});
    oe_n = 2'h3;
    cyc(1);
    $display("xfer done");
  endtask
  // Stores both ways, then stores an A port the section drives itself
  task automatic t_store;
    dir = 2'h3;
    a_drv = 18'h12345;
    cyc(1);
    oe_n = 2'h0;
    cap(2'h3, 2'h0);
    chk(a_st, 18'h12345);
    bsel = 2'h3;
    a_drv = 18'h0ABCD;
    cyc(1);
    chk(b_in, 18'h12345);
    oe_n = 2'h3;
    cyc(1);
    dir = 2'h0;
    asel = 2'h3;
    b_drv = 18'h2F00F;
    cap(2'h0, 2'h3);
    chk(b_st, 18'h2F00F);
    oe_n = 2'h0;
    b_drv = 18'h01111;
    cyc(1);
    chk(a_in, 18'h2F00F);
    cap(2'h3, 2'h0);
    chk(a_st, 18'h2F00F);
    oe_n = 2'h3;
    a_drv = 18'h3FFFF;
    cyc(2);
    chk(a_st, 18'h2F00F);
    bsel = 2'h0;
    asel = 2'h0;
    $display("store done");
  endtask
  task automatic t_sec;
    dir = 2'h2;
    a_drv = 18'h2A955;
    b_drv = 18'h00000;
    cyc(1);
    oe_n = 2'h1;
    cap(2'h1, 2'h0);
    chk(b_oe, 18'h3FE00);
    chk(b_in, 18'h2A800);
    chk(a_st, 18'h2F155);
    oe_n = 2'h3;
    cyc(1);
    $display("sections done");
  endtask
  task automatic t_test;
    test_mode_i = 1'h1;
    cyc(1);
    chk({a_out, a_oe}, {18'h2AAAA, 18'h3FFFF});
    chk({b_out, b_oe}, {18'h2AAAA, 18'h3FFFF});
    cap(2'h3, 2'h3);
    chk(a_st, 18'h2F155);
    test_mode_i = 1'h0;
    cyc(1);
    $display("test mode done");
  endtask
  task automatic t_fifo;
    int n;
    drain(n);
    chk(n, 4);
    dir = 2'h3;
    a_drv = 18'h00777;
    cyc(1);
    oe_n = 2'h0;
    sample_i = 1'h1;
    cyc(1);
    sample_i = 1'h0;
    chk(samp_a, 18'h00777);
    chk(samp_b, 18'h00777);
    chk(samp_valid, 1'h1);
    repeat (9) cap(2'h1, 2'h0);
    chk(b_in, 18'h00777);
    chk({log_accept, log_drop}, 2'h1);
    chk(log_data, {2'h0, 2'h1, 18'h00777, 18'h00777});
    drain(n);
    chk(n, 8);
    oe_n = 2'h3;
    $display("log done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence after 20 cycles of reset
  initial
  begin
    cyc(20);
    sys_rst_i = 1'h0;
    cyc(1);
    t_xfer;
    t_store;
    t_sec;
    t_test;
    t_fifo;
    summarize;
  end
  // Tests need about 110 cycles; far longer means a hang
  initial
  begin
    #20000;
    fail_count++;
    summarize;
  end
endmodule // rbt_top_tb

`default_nettype wire
